// [verilog/ctr_pkg.sv]
// constants and helpers of the serial ascii command responder
// assumes a byte-level uart outside the block on the same 100 MHz clock

package ctr_pkg;

   // -------------------------------------------------------------------------
   // characters
   // -------------------------------------------------------------------------
   localparam logic [7:0] CH_QUERY_START = 8'h24;
   localparam logic [7:0] CH_RANGE_CMD   = 8'h52;
   localparam logic [7:0] CH_ACK         = 8'h21;
   localparam logic [7:0] CH_NAK         = 8'h2d;
   localparam logic [7:0] CH_CR          = 8'h0d;
   localparam logic [7:0] CH_HASH        = 8'h23;
   localparam logic [7:0] CH_ZERO        = 8'h30;
   localparam logic [7:0] CH_ONE         = 8'h31;
   localparam logic [23:0] SIMPLE_PREFIX = 24'h3e2a2a;
   localparam logic [7:0] CMD_PRESSURE   = 8'h4d;
   localparam logic [7:0] CMD_TEMP       = 8'h43;
   localparam logic [7:0] CMD_ZERO       = 8'h5a;
   localparam logic [7:0] CMD_CORRECT    = 8'h4e;
   localparam logic [7:0] CMD_VALVE      = 8'h4f;
   localparam logic [7:0] CMD_VERSION    = 8'h49;
   localparam logic [7:0] CKSUM_ON_FIELD = 8'h40;

   // -------------------------------------------------------------------------
   // lengths and counts
   // -------------------------------------------------------------------------
   localparam int RANGE_CHARS   = 28;
   localparam int VERSION_CHARS = 6;
   localparam int BODY_DEPTH    = 32;
   localparam int RX_DEPTH      = 8;
   localparam logic [3:0] QUERY_LEN_PLAIN = 4'h4;
   localparam logic [3:0] QUERY_LEN_SUM   = 4'h6;
   localparam logic [5:0] RANGE_REPLY_LEN = 6'h1f;
   localparam logic [5:0] PRESS_REPLY_LEN = 6'h08;
   localparam logic [5:0] TEMP_REPLY_LEN  = 6'h04;
   localparam logic [5:0] ACK_REPLY_LEN   = 6'h01;
   localparam logic [5:0] VER_REPLY_LEN   = 6'h06;
   localparam int CLK_HZ        = 100000000;
   localparam int BAUD_RATE     = 9600;
   localparam int OVERSAMPLE    = 16;
   localparam logic [9:0] BAUD_DIV = 10'(CLK_HZ / (BAUD_RATE * OVERSAMPLE));

   // -------------------------------------------------------------------------
   // hex helpers
   // -------------------------------------------------------------------------
   function automatic logic [7:0] ctr_hex_char(input logic [3:0] v);
      return (v < 4'ha) ? (8'h30 + {4'h0, v}) : (8'h37 + {4'h0, v});
   endfunction

   // bit 4 flags a legal hex digit
   function automatic logic [4:0] ctr_hex_val(input logic [7:0] c);
      logic [4:0] r;
      r = 5'h00;
      if (c >= 8'h30 && c <= 8'h39) r = {1'b1, c[3:0]};
      else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
         r = {1'b1, 4'(c[3:0] + 4'h9)};
      return r;
   endfunction

endpackage

// [verilog/ctr_frame_if.sv]
// carrier between the command decoder and the reply sender
// assumes both ends sit on the same clock
`timescale 1ns/1ps

interface ctr_frame_if;
   logic                 start;
   logic [5:0]           len;
   logic [31:0][7:0]     body;
   logic                 add_sum;
   logic [7:0]           term;
   logic                 busy;

   modport src (output start, output len, output body, output add_sum, output term,
                input busy);
   modport snk (input start, input len, input body, input add_sum, input term,
                output busy);
endinterface

// [verilog/ctr_reply_sender.sv]
// streams a reply body, optional checksum pair and terminator as bytes
// assumes the body stays stable while busy is high
`timescale 1ns/1ps

module ctr_reply_sender (
   // clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_sys_rst,
   // frame request
   ctr_frame_if.snk        frm,
   // byte stream out
   output logic [7:0]      o_tx_data,
   output logic            o_tx_valid,
   input  wire logic       i_tx_ready
);

   typedef enum logic [2:0] {ST_IDLE, ST_BODY, ST_SUM_HI, ST_SUM_LO, ST_TERM} ctr_snd_st_t;

   typedef struct packed {
      ctr_snd_st_t st;
      logic [5:0]  idx;
      logic [7:0]  sum;
      logic [7:0]  data;
      logic        valid;
   } ctr_snd_t;

   ctr_snd_t s;
   ctr_snd_t next_s;
   logic [7:0] sum_now;
   logic [5:0] idx_nxt;

   // -------------------------------------------------------------------------
   // sequencing
   // -------------------------------------------------------------------------
   always_comb begin
      next_s  = s;
      sum_now = 8'(s.sum + s.data);
      idx_nxt = 6'(s.idx + 6'h01);
      case (s.st)
         ST_IDLE: begin
            if (frm.start) begin
               next_s.st    = ST_BODY;
               next_s.idx   = 6'h00;
               next_s.sum   = 8'h00;
               next_s.data  = frm.body[31];
               next_s.valid = 1'b1;
            end
         end
         ST_BODY: begin
            if (i_tx_ready) begin
               next_s.sum = sum_now;
               next_s.idx = idx_nxt;
               if (idx_nxt < frm.len) begin
                  next_s.data = frm.body[5'(31 - idx_nxt)];
               end else if (frm.add_sum) begin
                  next_s.st   = ST_SUM_HI;
                  next_s.data = ctr_pkg::ctr_hex_char(sum_now[7:4]);
               end else begin
                  next_s.st   = ST_TERM;
                  next_s.data = frm.term;
               end
            end
         end
         ST_SUM_HI: begin
            if (i_tx_ready) begin
               next_s.st   = ST_SUM_LO;
               next_s.data = ctr_pkg::ctr_hex_char(s.sum[3:0]);
            end
         end
         ST_SUM_LO: begin
            if (i_tx_ready) begin
               next_s.st   = ST_TERM;
               next_s.data = frm.term;
            end
         end
         ST_TERM: begin
            if (i_tx_ready) begin
               next_s.st    = ST_IDLE;
               next_s.valid = 1'b0;
            end
         end
         default: begin
            next_s = '0;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign frm.busy   = (s.st != ST_IDLE);
   assign o_tx_data  = s.data;
   assign o_tx_valid = s.valid;

endmodule

// [verilog/ctr_responder.sv]
// serial ascii command responder: addressed range query and simple protocol
// assumes a byte uart on the same clock delivering bytes with an error flag
`timescale 1ns/1ps

module ctr_responder (
   // clock and reset
   input  wire logic          i_sys_clk,
   input  wire logic          i_sys_rst,
   // received bytes from the uart
   input  wire logic [7:0]    i_rx_data,
   input  wire logic          i_rx_valid,
   input  wire logic          i_rx_error,
   // transmitted bytes to the uart
   output logic [7:0]         o_tx_data,
   output logic               o_tx_valid,
   input  wire logic          i_tx_ready,
   // 16x oversample enable for the uart
   output logic               o_baud_tick,
   // configuration
   input  wire logic          i_simple_protocol,
   input  wire logic [7:0]    i_station_address,
   input  wire logic [7:0]    i_checksum_enable_field,
   // measurement data, text first character in the top byte
   input  wire logic [23:0]   i_pressure_mag,
   input  wire logic          i_pressure_neg,
   input  wire logic [15:0]   i_temperature,
   input  wire logic [223:0]  i_range_text,
   input  wire logic [47:0]   i_version_text,
   // variant and valve status
   input  wire logic          i_absolute_variant,
   input  wire logic          i_display_variant,
   input  wire logic          i_valve_fitted,
   input  wire logic          i_caps_charged,
   // local zeroing pushbutton pin
   input  wire logic          i_zero_button,
   // offset actions toward the measurement path
   output logic               o_offset_zero,
   output logic               o_offset_correct,
   output logic               o_valve_zero
);

   // -------------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------------
   typedef struct packed {
      // addressed frame capture
      logic [7:0][7:0]  rxb;
      logic [3:0]       rxn;
      logic             rx_bad;

      // simple match window, newest byte lowest
      logic [31:0]      win;

      // reply for the sender, first character on top
      logic [31:0][7:0] body;
      logic [5:0]       len;
      logic             add_sum;
      logic [7:0]       term;
      logic             start;

      // button synchroniser and edge stage
      logic [2:0]       btn;

      // one-cycle strobes
      logic             zero;
      logic             corr;
      logic             valve;

      // uart oversample divider
      logic [9:0]       baud;
      logic             tick;
   } ctr_core_t;

   ctr_core_t s;
   ctr_core_t next_s;

   ctr_frame_if frm ();

   logic       cs_en;
   logic       zero_blocked;
   logic       btn_edge;

   // decoded hex digits, bit 4 set for a legal digit
   logic [4:0] addr_hi;
   logic [4:0] addr_lo;
   logic [4:0] sum_hi;
   logic [4:0] sum_lo;
   logic [7:0] query_sum;
   logic       addr_ok;
   logic       sum_ok;
   logic       query_ok;

   // -------------------------------------------------------------------------
   // decode helpers
   // -------------------------------------------------------------------------
   assign cs_en        = (i_checksum_enable_field == ctr_pkg::CKSUM_ON_FIELD);
   assign zero_blocked = i_absolute_variant | i_display_variant;
   assign btn_edge     = s.btn[1] & ~s.btn[2];

   assign addr_hi   = ctr_pkg::ctr_hex_val(s.rxb[1]);
   assign addr_lo   = ctr_pkg::ctr_hex_val(s.rxb[2]);
   assign sum_hi    = ctr_pkg::ctr_hex_val(s.rxb[4]);
   assign sum_lo    = ctr_pkg::ctr_hex_val(s.rxb[5]);
   assign query_sum = 8'(s.rxb[0] + s.rxb[1] + s.rxb[2] + s.rxb[3]);

   // full 00..ff address compare, both digits must be hex
   assign addr_ok = addr_hi[4] & addr_lo[4] &
                    ({addr_hi[3:0], addr_lo[3:0]} == i_station_address);

   // without checksum a frame carrying extra characters is a syntax error
   assign sum_ok = cs_en ?
                   ((s.rxn == ctr_pkg::QUERY_LEN_SUM) & sum_hi[4] & sum_lo[4] &
                    ({sum_hi[3:0], sum_lo[3:0]} == query_sum)) :
                   (s.rxn == ctr_pkg::QUERY_LEN_PLAIN);

   assign query_ok = ~s.rx_bad & (s.rxb[0] == ctr_pkg::CH_QUERY_START) &
                     (s.rxb[3] == ctr_pkg::CH_RANGE_CMD) & addr_ok & sum_ok;

   // -------------------------------------------------------------------------
   // next state
   // -------------------------------------------------------------------------
   always_comb begin
      // strobes default low, so each action lasts one cycle
      next_s       = s;
      next_s.start = 1'b0;
      next_s.zero  = 1'b0;
      next_s.corr  = 1'b0;
      next_s.valve = 1'b0;
      next_s.tick  = 1'b0;

      // uart oversample divider
      if (s.baud == 10'(ctr_pkg::BAUD_DIV - 10'h001)) begin
         next_s.baud = 10'h000;
         next_s.tick = 1'b1;
      end else begin
         next_s.baud = 10'(s.baud + 10'h001);
      end

      // pushbutton: two-stage sync, then edge detect on the second stage
      next_s.btn = {s.btn[1], s.btn[0], i_zero_button};
      if (btn_edge && !zero_blocked) begin
         next_s.zero = 1'b1;
      end

      // the protocol select decides which parser sees the byte
      if (i_rx_valid && i_simple_protocol) begin
         next_s.win = {s.win[23:0], i_rx_data};
         // simple-protocol replies go out only here, as answers to a complete request
         if (s.win[23:0] == ctr_pkg::SIMPLE_PREFIX && !frm.busy) begin
            next_s.win     = 32'h0000_0000;
            next_s.add_sum = 1'b0;
            next_s.term    = ctr_pkg::CH_HASH;

            case (i_rx_data)
               // sign pair first, point implied after the fourth digit
               ctr_pkg::CMD_PRESSURE: begin
                  next_s.body[31] = ctr_pkg::CH_ZERO;
                  next_s.body[30] = i_pressure_neg ? ctr_pkg::CH_ONE : ctr_pkg::CH_ZERO;
                  for (int k = 0; k < 6; k++) begin
                     next_s.body[29 - k] = ctr_pkg::ctr_hex_char(i_pressure_mag[23 - 4 * k -: 4]);
                  end
                  next_s.len   = ctr_pkg::PRESS_REPLY_LEN;
                  next_s.start = 1'b1;
               end

               // raw reading, the host does the scaling
               ctr_pkg::CMD_TEMP: begin
                  for (int k = 0; k < 4; k++) begin
                     next_s.body[31 - k] = ctr_pkg::ctr_hex_char(i_temperature[15 - 4 * k -: 4]);
                  end
                  next_s.len   = ctr_pkg::TEMP_REPLY_LEN;
                  next_s.start = 1'b1;
               end

               ctr_pkg::CMD_ZERO: begin
                  // blocked variants stay silent and keep their stored offset
                  if (!zero_blocked) begin
                     next_s.zero     = 1'b1;
                     next_s.body[31] = ctr_pkg::CH_ACK;
                     next_s.len      = ctr_pkg::ACK_REPLY_LEN;
                     next_s.start    = 1'b1;
                  end
               end

               // correction is allowed in every variant
               ctr_pkg::CMD_CORRECT: begin
                  next_s.corr     = 1'b1;
                  next_s.body[31] = ctr_pkg::CH_ACK;
                  next_s.len      = ctr_pkg::ACK_REPLY_LEN;
                  next_s.start    = 1'b1;
               end

               // a refusal still answers, but sends no strobe
               ctr_pkg::CMD_VALVE: begin
                  next_s.valve    = i_valve_fitted & i_caps_charged;
                  next_s.body[31] = (i_valve_fitted & i_caps_charged) ?
                                    ctr_pkg::CH_ACK : ctr_pkg::CH_NAK;
                  next_s.len      = ctr_pkg::ACK_REPLY_LEN;
                  next_s.start    = 1'b1;
               end

               ctr_pkg::CMD_VERSION: begin
                  for (int k = 0; k < ctr_pkg::VERSION_CHARS; k++) begin
                     next_s.body[31 - k] = i_version_text[47 - 8 * k -: 8];
                  end
                  next_s.len   = ctr_pkg::VER_REPLY_LEN;
                  next_s.start = 1'b1;
               end

               // window is already cleared, nothing goes out
               default: begin
                  next_s.start = 1'b0;
               end
            endcase
         end
      end else if (i_rx_valid) begin
         if (i_rx_data == ctr_pkg::CH_CR) begin
            // any failed check drops the frame with no reply at all
            if (query_ok && !i_rx_error && !frm.busy) begin
               next_s.body[31] = ctr_pkg::CH_ACK;
               next_s.body[30] = ctr_pkg::ctr_hex_char(i_station_address[7:4]);
               next_s.body[29] = ctr_pkg::ctr_hex_char(i_station_address[3:0]);
               for (int k = 0; k < ctr_pkg::RANGE_CHARS; k++) begin
                  next_s.body[28 - k] = i_range_text[223 - 8 * k -: 8];
               end
               next_s.len     = ctr_pkg::RANGE_REPLY_LEN;
               next_s.add_sum = cs_en;
               next_s.term    = ctr_pkg::CH_CR;
               next_s.start   = 1'b1;
            end

            // a terminator always ends the frame
            next_s.rxn    = 4'h0;
            next_s.rx_bad = 1'b0;
         end else if (i_rx_data == ctr_pkg::CH_QUERY_START) begin
            // a start delimiter resynchronises after line noise
            next_s.rxb[0] = i_rx_data;
            next_s.rxn    = 4'h1;
            next_s.rx_bad = i_rx_error;
         end else begin
            // an overlong frame is poisoned, not wrapped
            if (s.rxn < 4'(ctr_pkg::RX_DEPTH)) begin
               next_s.rxb[s.rxn[2:0]] = i_rx_data;
               next_s.rxn             = 4'(s.rxn + 4'h1);
            end else begin
               next_s.rx_bad = 1'b1;
            end

            if (i_rx_error) begin
               next_s.rx_bad = 1'b1;
            end
         end
      end
   end

   // one register holds the whole core state
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // -------------------------------------------------------------------------
   // reply sender
   // -------------------------------------------------------------------------
   assign frm.start   = s.start;
   assign frm.len     = s.len;
   assign frm.body    = s.body;
   assign frm.add_sum = s.add_sum;
   assign frm.term    = s.term;

   // body, len and term are read live, so they change only while idle
   ctr_reply_sender u_sender (
      .i_sys_clk  (i_sys_clk),
      .i_sys_rst  (i_sys_rst),
      .frm        (frm.snk),
      .o_tx_data  (o_tx_data),
      .o_tx_valid (o_tx_valid),
      .i_tx_ready (i_tx_ready)
   );

   // strobes and tick leave straight from flip-flops
   assign o_baud_tick      = s.tick;
   assign o_offset_zero    = s.zero;
   assign o_offset_correct = s.corr;
   assign o_valve_zero     = s.valve;

endmodule

// [bench/ctr_responder_assertions.sv]
// port checker of the serial command responder
// assumes binding into ctr_responder on its single clock
`timescale 1ns/1ps

module ctr_responder_assertions (
   // clock and reset
   input wire logic       i_sys_clk,
   input wire logic       i_sys_rst,
   // byte streams
   input wire logic [7:0] i_rx_data,
   input wire logic       i_rx_valid,
   input wire logic       i_rx_error,
   input wire logic [7:0] o_tx_data,
   input wire logic       o_tx_valid,
   input wire logic       i_tx_ready,
   input wire logic       o_baud_tick,
   // configuration and status
   input wire logic       i_simple_protocol,
   input wire logic       i_absolute_variant,
   input wire logic       i_valve_fitted,
   input wire logic       i_caps_charged,
   // offset actions
   input wire logic       o_offset_zero,
   input wire logic       o_offset_correct,
   input wire logic       o_valve_zero
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   logic [9:0] cnt;
   logic       seen;
   // the first tick only arms the period check, its phase is free
   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt  <= 10'h000;
         seen <= 1'b0;
      end else begin
         cnt  <= o_baud_tick ? 10'h000 : cnt + 10'h001;
         seen <= seen | o_baud_tick;
      end
   end
   a_tx_holds_byte: assert property (o_tx_valid && !i_tx_ready |=>
      o_tx_valid && $stable(o_tx_data)) else $error("tx byte dropped while stalled");
   a_reply_has_cause: assert property ($rose(o_tx_valid) |-> $past(i_rx_valid, 2))
      else $error("reply without request");
   a_correct_then_ack: assert property (o_offset_correct |=>
      o_tx_valid && o_tx_data == 8'h21) else $error("correction reply wrong");
   a_valve_then_ack: assert property (o_valve_zero |=>
      o_tx_valid && o_tx_data == 8'h21) else $error("valve reply wrong");
   a_valve_needs_caps: assert property (o_valve_zero |->
      $past(i_valve_fitted) && $past(i_caps_charged)) else $error("valve zero not allowed");
   a_variant_no_zero: assert property (i_absolute_variant &&
      $past(i_absolute_variant, 4) |-> !o_offset_zero) else $error("variant zeroed");
   a_pressure_sign_first: assert property ($rose(o_tx_valid) && i_simple_protocol &&
      $past(i_rx_data, 2) == 8'h4d |-> o_tx_data == 8'h30) else $error("bad sign char");
   a_range_ack_lead: assert property ($rose(o_tx_valid) && !i_simple_protocol |->
      o_tx_data == 8'h21) else $error("range reply lead wrong");
   a_error_stays_silent: assert property (!i_simple_protocol && i_rx_valid && i_rx_error
      && !o_tx_valid && $past(i_rx_data) != 8'h0d && $past(i_rx_data, 2) != 8'h0d
      |=> !o_tx_valid [*2]) else $error("reply after line error");
   a_baud_period: assert property (seen |-> o_baud_tick == (cnt == 10'h28a))
      else $error("baud tick period wrong");
   c_correct: cover property (o_offset_correct);
   c_valve: cover property (o_valve_zero);
   c_range: cover property ($rose(o_tx_valid) && !i_simple_protocol);
endmodule

bind ctr_responder ctr_responder_assertions u_chk (.i_sys_clk(i_sys_clk),
   .i_sys_rst(i_sys_rst), .i_rx_data(i_rx_data), .i_rx_valid(i_rx_valid),
   .i_rx_error(i_rx_error), .o_tx_data(o_tx_data), .o_tx_valid(o_tx_valid),
   .i_tx_ready(i_tx_ready), .o_baud_tick(o_baud_tick), .i_simple_protocol(i_simple_protocol),
   .i_absolute_variant(i_absolute_variant), .i_valve_fitted(i_valve_fitted),
   .i_caps_charged(i_caps_charged), .o_offset_zero(o_offset_zero),
   .o_offset_correct(o_offset_correct), .o_valve_zero(o_valve_zero));

// [bench/ctr_host_model.sv]
// far-side host model: takes reply bytes, stalling when asked
// assumes the responder clock; bytes are kept in order for the bench
`timescale 1ns/1ps

module ctr_host_model (
   // clock
   input  wire logic       i_sys_clk,
   // reply bytes
   input  wire logic [7:0] i_tx_data,
   input  wire logic       i_tx_valid,
   output logic            o_tx_ready,
   // stall control from the bench
   input  wire logic       i_stall
);
   logic [7:0] got[$];
   initial o_tx_ready = 1'b1;
   // a byte counts only at a valid and ready edge
   always @(posedge i_sys_clk) begin
      if (i_tx_valid && o_tx_ready) got.push_back(i_tx_data);
      o_tx_ready <= #1 i_stall ? ~o_tx_ready : 1'b1;
   end
   function automatic int celsius(input logic [15:0] v);
      return int'(v) / 256 - 128;
   endfunction
endmodule

// [bench/ctr_responder_tb.sv]
// self-checking bench of the serial command responder
// assumes the host model and the bound checker are compiled with it
`timescale 1ns/1ps

module ctr_responder_tb;
   logic         clk, rst, rx_v, rx_e, stall, simple, neg, abs_v, disp_v, fit, chg, btn;
   logic [7:0]   rx_d, addr, ckf, tx_d;
   logic [23:0]  mag;
   logic [15:0]  temp;
   logic [223:0] rng;
   logic         tx_v, tx_r, tick, p_zero, p_corr, p_valve;
   logic [7:0]   exp[$];
   int           failures = 0, checks_done = 0, n_zero = 0, n_corr = 0, n_valve = 0;

   ctr_responder u_ctr_responder (
      .i_sys_clk(clk), .i_sys_rst(rst), .i_rx_data(rx_d), .i_rx_valid(rx_v),
      .i_rx_error(rx_e), .o_tx_data(tx_d), .o_tx_valid(tx_v), .i_tx_ready(tx_r),
      .o_baud_tick(tick), .i_simple_protocol(simple), .i_station_address(addr),
      .i_checksum_enable_field(ckf), .i_pressure_mag(mag), .i_pressure_neg(neg),
      .i_temperature(temp), .i_range_text(rng), .i_version_text(48'h5320362e3039),
      .i_absolute_variant(abs_v), .i_display_variant(disp_v), .i_valve_fitted(fit),
      .i_caps_charged(chg), .i_zero_button(btn), .o_offset_zero(p_zero),
      .o_offset_correct(p_corr), .o_valve_zero(p_valve));
   ctr_host_model u_ctr_host_model (.i_sys_clk(clk), .i_tx_data(tx_d), .i_tx_valid(tx_v),
      .o_tx_ready(tx_r), .i_stall(stall));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (p_zero === 1'b1) n_zero++;
      if (p_corr === 1'b1) n_corr++;
      if (p_valve === 1'b1) n_valve++;
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic conclude;
      if (failures == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   function automatic logic [7:0] hx(input logic [3:0] v);
      return (v < 4'ha) ? 8'h30 + v : 8'h37 + v;
   endfunction
   task automatic send(input logic [7:0] b, input logic e);
      @(posedge clk);
      #1 rx_d = b;
      rx_e = e;
      rx_v = 1'b1;
      @(posedge clk);
      #1 rx_v = 1'b0;
      rx_e = 1'b0;
   endtask
   task automatic cmd(input logic [7:0] c);
      send(8'h3e, 1'b0);
      send(8'h2a, 1'b0);
      send(8'h2a, 1'b0);
      send(c, 1'b0);
   endtask
   // waits for the expected count, then a quiet spell to catch extra bytes
   task automatic expect_reply;
      int n;
      for (int i = 0; i < 400 && u_ctr_host_model.got.size() < exp.size(); i++) @(posedge clk);
      repeat (12) @(posedge clk);
      n = u_ctr_host_model.got.size();
      check(n, exp.size());
      foreach (exp[i]) if (i < n) check(u_ctr_host_model.got[i], exp[i]);
      u_ctr_host_model.got.delete();
      #1;
   endtask
   task automatic query(input logic [7:0] a, input logic sum_on, input logic [7:0] bad,
                        input logic err);
      logic [7:0] s;
      s = 8'h24 + hx(a[7:4]) + hx(a[3:0]) + 8'h52 + bad;
      send(8'h24, 1'b0);
      send(hx(a[7:4]), 1'b0);
      send(hx(a[3:0]), 1'b0);
      send(8'h52, err);
      if (sum_on) send(hx(s[7:4]), 1'b0);
      if (sum_on) send(hx(s[3:0]), 1'b0);
      send(8'h0d, 1'b0);
   endtask
   task automatic range_exp(input logic sum_on);
      logic [7:0] s;
      exp = '{8'h21, hx(addr[7:4]), hx(addr[3:0])};
      for (int i = 0; i < 28; i++) exp.push_back(rng[223 - 8 * i -: 8]);
      s = 8'h00;
      foreach (exp[i]) s += exp[i];
      if (sum_on) exp.push_back(hx(s[7:4]));
      if (sum_on) exp.push_back(hx(s[3:0]));
      exp.push_back(8'h0d);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_values;
      {mag, neg, temp} = {24'h00a45f, 1'b1, 16'h9e20};
      cmd(8'h4d);
      exp = '{8'h30, 8'h31, 8'h30, 8'h30, 8'h41, 8'h34, 8'h35, 8'h46, 8'h23};
      expect_reply();
      {mag, neg} = {24'h12c3e0, 1'b0};
      cmd(8'h4d);
      exp = '{8'h30, 8'h30, 8'h31, 8'h32, 8'h43, 8'h33, 8'h45, 8'h30, 8'h23};
      expect_reply();
      cmd(8'h43);
      exp = '{8'h39, 8'h45, 8'h32, 8'h30, 8'h23};
      expect_reply();
      check(u_ctr_host_model.celsius(temp), 32'h0000_001e);
      cmd(8'h49);
      exp = '{8'h53, 8'h20, 8'h36, 8'h2e, 8'h30, 8'h39, 8'h23};
      expect_reply();
   endtask
   task automatic t_offsets;
      cmd(8'h5a);
      exp = '{8'h21, 8'h23};
      expect_reply();
      check(n_zero, 1);
      cmd(8'h4e);
      expect_reply();
      check(n_corr, 1);
      exp.delete();
      abs_v = 1'b1;
      cmd(8'h5a);
      expect_reply();
      {abs_v, disp_v} = 2'b01;
      cmd(8'h5a);
      expect_reply();
      disp_v = 1'b0;
      check(n_zero, 1);
      btn = 1'b1;
      repeat (8) @(posedge clk);
      #1 btn = 1'b0;
      check(n_zero, 2);
   endtask
   task automatic t_valve;
      {fit, chg} = 2'b11;
      cmd(8'h4f);
      exp = '{8'h21, 8'h23};
      expect_reply();
      exp = '{8'h2d, 8'h23};
      for (int k = 0; k < 2; k++) begin
         {fit, chg} = k ? 2'b01 : 2'b10;
         cmd(8'h4f);
         expect_reply();
      end
      check(n_valve, 1);
      exp.delete();
      cmd(8'h41);
      expect_reply();
      send(8'h3e, 1'b0);
      send(8'h2a, 1'b0);
      send(8'h41, 1'b0);
      send(8'h4d, 1'b0);
      expect_reply();
   endtask
   task automatic t_range;
      logic [7:0] al[3] = '{8'h00, 8'hff, 8'hb7};
      simple = 1'b0;
      stall = 1'b1;
      foreach (al[k]) begin
         addr = al[k];
         query(addr, 1'b0, 8'h00, 1'b0);
         range_exp(1'b0);
         expect_reply();
      end
      stall = 1'b0;
      exp.delete();
      query(addr ^ 8'h01, 1'b0, 8'h00, 1'b0);
      expect_reply();
      query(addr, 1'b0, 8'h00, 1'b1);
      expect_reply();
      ckf = 8'h40;
      query(addr, 1'b1, 8'h00, 1'b0);
      range_exp(1'b1);
      expect_reply();
      exp.delete();
      query(addr, 1'b1, 8'h01, 1'b0);
      expect_reply();
      query(addr, 1'b0, 8'h00, 1'b0);
      expect_reply();
   endtask

   initial begin
      {rx_v, rx_e, stall, neg, abs_v, disp_v, fit, chg, btn} = '0;
      {rx_d, ckf, mag, temp} = '0;
      {rst, simple, addr} = {1'b1, 1'b1, 8'hb7};
      for (int i = 0; i < 28; i++) rng[223 - 8 * i -: 8] = 8'h41 + 8'(i);
      repeat (8) @(posedge clk);
      #1 rst = 1'b0;
      t_values();
      t_offsets();
      t_valve();
      t_range();
      conclude();
   end
   initial begin
      repeat (30000) @(posedge clk);
      failures++;
      conclude();
   end
endmodule
